// ==== rtl/canif_ctrl.sv ====
// can host control: interrupt enables, transmit flags, abort handshake, acceptance filter
//
// Operation
// - wake enable gates wake flag onto interrupt
// - six error enables gate flags onto error irq
// - receive full enable raises receive interrupt
// - soft reset holds enable, flag, control registers
// - ack read only; write one clears empty
// - clearing empty also clears abort acknowledge
// - host clears empty; device sets when sent
// - granted abort sets empty and acknowledge
// - empty flag with enable requests tx interrupt
// - setting empty clears abort request; host cannot
// - grant abort if not started or failed
// - mode selects 32/16/8 filters or closed
// - hit field updated on foreground copy
// - filter registers writable only in soft reset
// - error counters read only, read in sleep/reset
// - background message signalled only when accepted
// - code/mask applied to four identifier bytes
// - clear mask bit requires equal bit
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module canif_ctrl #(
  parameter int ID_BYTES = 4
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  // apb slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [7:0]               paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic      [31:0]              prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // status from the receive flag logic and engine
  input  wire canif_pkg::canif_flags_t  flags_i,
  input  wire logic [7:0]               rx_err_cnt_i,
  input  wire logic [7:0]               tx_err_cnt_i,
  input  wire logic                     sleep_i,
  input  wire canif_pkg::canif_tx_evt_t tx_evt_i,
  // background buffer identifier
  input  wire logic                     rx_done_i,
  input  wire logic                     rx_ext_i,
  input  wire logic [ID_BYTES*8-1:0]    rx_id_i,
  // outputs
  output logic                          wake_irq_o,
  output logic                          err_irq_o,
  output logic                          rx_irq_o,
  output logic                          tx_irq_o,
  output logic      [2:0]               tx_sched_o,
  output logic      [2:0]               abort_req_o,
  output logic                          rx_accept_o,
  output logic                          soft_reset_o
);

  localparam int NB = canif_pkg::NUM_TX_BUF;

  if (ID_BYTES != 4) begin : g_chk
    $error("canif_ctrl: ID_BYTES must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states except code/mask reads, which take one
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wbyte;
  logic       sel_irq_en;
  logic       sel_tx_flags;
  logic       sel_tx_ctrl;
  logic       sel_mode;
  logic       sel_rx_err;
  logic       sel_tx_err;
  logic       sel_mod_ctrl;
  logic       sel_rx_stat;
  logic       sel_code;
  logic       sel_mask;
  logic       sel_any;
  assign wr_en        = psel_i && penable_i && pwrite_i;
  assign rd_en        = psel_i && !penable_i && !pwrite_i;
  assign wbyte        = pwdata_i[7:0];
  assign sel_irq_en   = paddr_i == canif_pkg::ADDR_RX_IRQ_EN;
  assign sel_tx_flags = paddr_i == canif_pkg::ADDR_TX_FLAGS;
  assign sel_tx_ctrl  = paddr_i == canif_pkg::ADDR_TX_CTRL;
  assign sel_mode     = paddr_i == canif_pkg::ADDR_FILT_MODE;
  assign sel_rx_err   = paddr_i == canif_pkg::ADDR_RX_ERR_CNT;
  assign sel_tx_err   = paddr_i == canif_pkg::ADDR_TX_ERR_CNT;
  assign sel_mod_ctrl = paddr_i == canif_pkg::ADDR_MOD_CTRL;
  assign sel_rx_stat  = paddr_i == canif_pkg::ADDR_RX_STATUS;
  assign sel_code     = paddr_i[7:4] == canif_pkg::ADDR_CODE_BASE[7:4] && paddr_i[3:2] != 2'h0
                        ? 1'b1 : paddr_i[7:4] == canif_pkg::ADDR_CODE_BASE[7:4];
  assign sel_mask     = paddr_i[7:4] == canif_pkg::ADDR_MASK_BASE[7:4];
  assign sel_any      = sel_irq_en | sel_tx_flags | sel_tx_ctrl | sel_mode | sel_rx_err
                        | sel_tx_err | sel_mod_ctrl | sel_rx_stat
                        | ((sel_code | sel_mask) && paddr_i[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // module control: soft reset bit
  logic soft_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      soft_q <= canif_pkg::SOFT_RST_RST;
    end else if (wr_en && sel_mod_ctrl) begin
      soft_q <= wbyte[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive interrupt enables
  logic [7:0] irq_en_q;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_en_q <= canif_pkg::RX_IRQ_EN_RST;
    end else if (soft_q) begin
      irq_en_q <= canif_pkg::RX_IRQ_EN_RST;
    end else if (wr_en && sel_irq_en) begin
      irq_en_q <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit flags, control, abort handshake
  logic [NB-1:0] empty_q;
  logic [NB-1:0] ack_q;
  logic [NB-1:0] abreq_q;
  logic [NB-1:0] txie_q;
  logic [NB-1:0] host_clr;
  logic [NB-1:0] grant;
  logic [NB-1:0] dev_set;
  logic [NB-1:0] empty_d;
  logic [NB-1:0] ack_d;
  logic [NB-1:0] abreq_d;

  // host clears an empty flag by writing one
  assign host_clr = (wr_en && sel_tx_flags)
                    ? wbyte[canif_pkg::TX_EMPTY_LSB +: NB] & empty_q : '0;
  // abort granted if not started or the attempt failed
  assign grant    = abreq_q & ~empty_q
                    & (~tx_evt_i.started | tx_evt_i.failed) & ~tx_evt_i.sent_ok;
  assign dev_set  = (tx_evt_i.sent_ok & ~empty_q) | grant;
  // device set wins over host clear in the same cycle
  assign empty_d  = (empty_q & ~host_clr) | dev_set;
  assign ack_d    = dev_set != '0 || host_clr != '0
                    ? ((ack_q & ~host_clr) & ~(tx_evt_i.sent_ok & ~empty_q)) | grant
                    : ack_q;
  // host may only set a request; setting empty clears it
  assign abreq_d  = (abreq_q | ((wr_en && sel_tx_ctrl)
                    ? wbyte[canif_pkg::ABORT_LSB +: NB] & ~empty_q : '0)) & ~dev_set;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      empty_q <= canif_pkg::TX_EMPTY_RST;
      ack_q   <= '0;
      abreq_q <= '0;
      txie_q  <= '0;
    end else if (soft_q) begin
      empty_q <= canif_pkg::TX_EMPTY_RST;
      ack_q   <= '0;
      abreq_q <= '0;
      txie_q  <= '0;
    end else begin
      empty_q <= empty_d;
      ack_q   <= ack_d;
      abreq_q <= abreq_d;
      if (wr_en && sel_tx_ctrl) begin
        txie_q <= wbyte[canif_pkg::TX_EMPTY_LSB +: NB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acceptance mode and code/mask storage
  logic [1:0] mode_q;
  logic [1:0] hit_q;
  logic       mem_we;
  logic [2:0] mem_waddr;
  logic [2:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [63:0] mem_all;
  logic [31:0] code_w;
  logic [31:0] mask_w;
  assign mem_we    = wr_en && (sel_code || sel_mask) && soft_q;
  assign mem_waddr = {sel_mask, paddr_i[3:2]};
  assign mem_raddr = {sel_mask, paddr_i[3:2]};
  assign code_w    = mem_all[31:0];
  assign mask_w    = mem_all[63:32];

  canif_regmem #(
    .WORDS (8)
  ) u_mem (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (wbyte),
    .raddr_i   (mem_raddr),
    .rdata_o   (mem_rdata),
    .all_o     (mem_all)
  );

  ////////////////////////////////////////////////////////////////////////////
  // filter compare: per-bit match, mask set means don't care
  logic [31:0] bit_ok;
  logic [3:0]  byte_ok;
  logic [3:0]  filt_hit;
  logic        accept;
  logic [1:0]  hit_d;
  assign bit_ok = ~(rx_id_i ^ code_w) | mask_w;
  generate
    for (genvar b = 0; b < 4; b++) begin : g_byte
      assign byte_ok[b] = &bit_ok[b*8 +: 8];
    end
  endgenerate
  // in 32-bit mode standard identifiers only use the first two bytes
  always_comb begin
    filt_hit = '0;
    case (canif_pkg::canif_mode_t'(mode_q))
      canif_pkg::CANIF_MODE_32: begin
        filt_hit[0] = byte_ok[0] & byte_ok[1] & (~rx_ext_i | (byte_ok[2] & byte_ok[3]));
      end
      canif_pkg::CANIF_MODE_16: begin
        filt_hit[0] = byte_ok[0] & byte_ok[1];
        filt_hit[1] = byte_ok[2] & byte_ok[3];
      end
      canif_pkg::CANIF_MODE_8: begin
        filt_hit = byte_ok;
      end
      canif_pkg::CANIF_MODE_CLOSED: begin
        filt_hit = '0;
      end
      default: begin
        filt_hit = '0;
      end
    endcase
  end
  assign accept = filt_hit != '0;
  assign hit_d  = filt_hit[0] ? 2'h0 : filt_hit[1] ? 2'h1 : filt_hit[2] ? 2'h2 : 2'h3;

  logic fg_copy;
  // copy to foreground only when released and accepted
  assign fg_copy = rx_done_i && accept && !flags_i.rx_full && !soft_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= '0;
      hit_q  <= '0;
    end else begin
      if (wr_en && sel_mode && soft_q) begin
        mode_q <= wbyte[canif_pkg::MODE_LSB +: 2];
      end
      if (fg_copy) begin
        hit_q <= hit_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [7:0]  rd_byte;
  logic        rd_mem_pend_q;
  logic        rd_mem;
  logic [7:0]  tx_flag_byte;
  logic [7:0]  tx_ctrl_byte;
  logic [7:0]  mode_byte;
  assign tx_flag_byte = {1'b0, ack_q, 1'b0, empty_q};
  assign tx_ctrl_byte = {1'b0, abreq_q, 1'b0, txie_q};
  assign mode_byte    = {2'h0, mode_q, 2'h0, hit_q};
  assign rd_byte = sel_irq_en   ? irq_en_q
                 : sel_tx_flags ? tx_flag_byte
                 : sel_tx_ctrl  ? tx_ctrl_byte
                 : sel_mode     ? mode_byte
                 : sel_rx_err   ? rx_err_cnt_i
                 : sel_tx_err   ? tx_err_cnt_i
                 : sel_mod_ctrl ? {7'h00, soft_q}
                 : sel_rx_stat  ? {7'h00, sleep_i}
                 : canif_pkg::BYTE_ZERO;

  assign rd_mem = rd_en && (sel_code || sel_mask);

  // code/mask reads take one wait state: their byte leaves a register a cycle late
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o      <= '0;
      pready_o      <= 1'b0;
      pslverr_o     <= 1'b0;
      rd_mem_pend_q <= 1'b0;
    end else begin
      rd_mem_pend_q <= rd_mem;
      pready_o      <= (psel_i && !penable_i && !rd_mem) || rd_mem_pend_q;
      pslverr_o     <= psel_i && !penable_i && !sel_any;
      if (rd_en) begin
        prdata_o <= {24'h000000, rd_byte};
      end else if (rd_mem_pend_q) begin
        prdata_o <= {24'h000000, mem_rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests and outputs
  logic [5:0] err_pair;
  assign err_pair = {flags_i.rx_warn & irq_en_q[canif_pkg::RX_WARN_BIT],
                     flags_i.tx_warn & irq_en_q[canif_pkg::TX_WARN_BIT],
                     flags_i.rx_pass & irq_en_q[canif_pkg::RX_PASS_BIT],
                     flags_i.tx_pass & irq_en_q[canif_pkg::TX_PASS_BIT],
                     flags_i.busoff  & irq_en_q[canif_pkg::BUSOFF_BIT],
                     flags_i.overrun & irq_en_q[canif_pkg::OVERRUN_BIT]};

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wake_irq_o   <= 1'b0;
      err_irq_o    <= 1'b0;
      rx_irq_o     <= 1'b0;
      tx_irq_o     <= 1'b0;
      tx_sched_o   <= '0;
      abort_req_o  <= '0;
      rx_accept_o  <= 1'b0;
      soft_reset_o <= 1'b1;
    end else begin
      wake_irq_o   <= flags_i.wake & irq_en_q[canif_pkg::WAKE_BIT];
      err_irq_o    <= |err_pair;
      rx_irq_o     <= flags_i.rx_full & irq_en_q[canif_pkg::RX_FULL_BIT];
      tx_irq_o     <= |(empty_q & txie_q);
      tx_sched_o   <= ~empty_q;
      abort_req_o  <= abreq_q;
      rx_accept_o  <= fg_copy;
      soft_reset_o <= soft_q;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/canif_pkg.sv ====
// package: register map, field layout and shared types of the can interrupt/filter block
package canif_pkg;

  // register byte addresses (aligned words)
  localparam logic [7:0] ADDR_RX_IRQ_EN   = 8'h00;
  localparam logic [7:0] ADDR_TX_FLAGS    = 8'h04;
  localparam logic [7:0] ADDR_TX_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_FILT_MODE   = 8'h0C;
  localparam logic [7:0] ADDR_RX_ERR_CNT  = 8'h10;
  localparam logic [7:0] ADDR_TX_ERR_CNT  = 8'h14;
  localparam logic [7:0] ADDR_MOD_CTRL    = 8'h18;
  localparam logic [7:0] ADDR_RX_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_CODE_BASE   = 8'h20;
  localparam logic [7:0] ADDR_MASK_BASE   = 8'h30;

  // receive interrupt enable bit positions
  localparam int RX_FULL_BIT  = 0;
  localparam int OVERRUN_BIT  = 1;
  localparam int BUSOFF_BIT   = 2;
  localparam int TX_PASS_BIT  = 3;
  localparam int RX_PASS_BIT  = 4;
  localparam int TX_WARN_BIT  = 5;
  localparam int RX_WARN_BIT  = 6;
  localparam int WAKE_BIT     = 7;

  // field layout of transmit flags / control
  localparam int NUM_TX_BUF   = 3;
  localparam int TX_EMPTY_LSB = 0;
  localparam int ABORT_LSB    = 4;

  // filter mode / hit field positions
  localparam int MODE_LSB     = 4;
  localparam int HIT_LSB      = 0;

  // reset values
  localparam logic [7:0] RX_IRQ_EN_RST = 8'h00;
  localparam logic [2:0] TX_EMPTY_RST  = 3'h7;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic       SOFT_RST_RST  = 1'b1;

  typedef enum logic [1:0] {
    CANIF_MODE_32 = 2'h0,
    CANIF_MODE_16 = 2'h1,
    CANIF_MODE_8  = 2'h2,
    CANIF_MODE_CLOSED = 2'h3
  } canif_mode_t;

  // per-buffer events from the protocol engine
  typedef struct packed {
    logic [2:0] sent_ok;
    logic [2:0] started;
    logic [2:0] failed;
  } canif_tx_evt_t;

  // error status flags from the receive flag logic
  typedef struct packed {
    logic wake;
    logic rx_warn;
    logic tx_warn;
    logic rx_pass;
    logic tx_pass;
    logic busoff;
    logic overrun;
    logic rx_full;
  } canif_flags_t;

endpackage

// ==== rtl/canif_regmem.sv ====
// small register memory holding acceptance code and mask bytes
`timescale 1ns/10ps
`default_nettype none
module canif_regmem #(
  parameter int WORDS = 8
) (
  // clock and reset
  input  wire logic                     clk_sys_i,
  input  wire logic                     reset_i,
  // write port
  input  wire logic                     we_i,
  input  wire logic [$clog2(WORDS)-1:0] waddr_i,
  input  wire logic [7:0]               wdata_i,
  // read port
  input  wire logic [$clog2(WORDS)-1:0] raddr_i,
  output logic      [7:0]               rdata_o,
  // full contents for the comparators
  output logic      [WORDS*8-1:0]       all_o
);

  localparam int AW = $clog2(WORDS);

  logic [7:0] mem_q [WORDS];

  if (WORDS < 2) begin : g_chk
    $error("canif_regmem: WORDS too small");
  end

  generate
    for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
          mem_q[i] <= canif_pkg::BYTE_ZERO;
        end else if (we_i && waddr_i == AW'(i)) begin
          mem_q[i] <= wdata_i;
        end
      end
      assign all_o[i*8 +: 8] = mem_q[i];
    end
  endgenerate

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= canif_pkg::BYTE_ZERO;
    end else begin
      rdata_o <= mem_q[raddr_i];
    end
  end

endmodule
`default_nettype wire

// ==== sim/canif_ctrl_sva.sv ====
// port assertions for the can host control block
`timescale 1ns/10ps
`default_nettype none
module canif_ctrl_chk (
  // clock and reset
  input wire logic                     clk_sys_i,
  input wire logic                     reset_i,
  // observed ports
  input wire logic                     psel_i,
  input wire logic                     penable_i,
  input wire logic                     pready_o,
  input wire canif_pkg::canif_flags_t  flags_i,
  input wire canif_pkg::canif_tx_evt_t tx_evt_i,
  input wire logic                     rx_done_i,
  input wire logic                     wake_irq_o,
  input wire logic                     err_irq_o,
  input wire logic                     rx_irq_o,
  input wire logic                     tx_irq_o,
  input wire logic [2:0]               tx_sched_o,
  input wire logic [2:0]               abort_req_o,
  input wire logic                     rx_accept_o,
  input wire logic                     soft_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////
  a_apb_ready: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access phase without ready");
  a_wake_gate: assert property (wake_irq_o |-> $past(flags_i.wake))
    else $error("wake irq without wake flag");
  a_err_gate: assert property (err_irq_o |-> $past(|flags_i[6:1]))
    else $error("error irq without error flag");
  a_rx_gate: assert property (rx_irq_o |-> $past(flags_i.rx_full))
    else $error("receive irq without full flag");
  a_tx_gate: assert property (tx_irq_o |-> tx_sched_o != 3'h7)
    else $error("tx irq with no empty buffer");
  a_abort_empty: assert property ((abort_req_o & ~tx_sched_o) == 3'h0)
    else $error("abort pending on empty buffer");
  a_sent_done: assert property ((tx_evt_i.sent_ok & tx_sched_o) != 3'h0 |=> ##1
    (tx_sched_o & $past(tx_evt_i.sent_ok, 2)) == 3'h0)
    else $error("sent buffer not flagged empty");
  a_abort_grant: assert property ((abort_req_o & ~tx_evt_i.started) != 3'h0
    |-> ##[1:3] abort_req_o == 3'h0)
    else $error("idle abort not granted");
  a_soft_quiet: assert property (soft_reset_o |=> !rx_irq_o && !err_irq_o && !wake_irq_o
    && !tx_irq_o && tx_sched_o == 3'h0 && abort_req_o == 3'h0)
    else $error("state not held in soft reset");
  a_accept_src: assert property (rx_accept_o |-> $past(rx_done_i) || $past(rx_done_i, 2))
    else $error("accept without received frame");
endmodule
bind canif_ctrl canif_ctrl_chk u_chk (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pready_o,
  .flags_i, .tx_evt_i, .rx_done_i, .wake_irq_o, .err_irq_o, .rx_irq_o, .tx_irq_o,
  .tx_sched_o, .abort_req_o, .rx_accept_o, .soft_reset_o);
`default_nettype wire

// ==== sim/canif_node_model.sv ====
// far-side can node: sends, fails or stalls scheduled buffers and delivers frames
`timescale 1ns/10ps
`default_nettype none
module canif_node_model (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  // bench controls
  input  wire logic                slow_i,
  input  wire logic                fail_i,
  input  wire logic                frame_i,
  input  wire logic [32:0]         frame_id_i,
  // device side
  input  wire logic [2:0]          tx_sched_i,
  output canif_pkg::canif_tx_evt_t tx_evt_o,
  output logic                     rx_done_o,
  output logic                     rx_ext_o,
  output logic [31:0]              rx_id_o
);
  int         cnt;
  int         lead;
  logic [1:0] sel;
  // one buffer served at a time, lowest index first
  assign sel = tx_sched_i[0] ? 2'h0 : tx_sched_i[1] ? 2'h1 : tx_sched_i[2] ? 2'h2 : 2'h3;
  assign lead = slow_i ? 40 : 1;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 0;
      tx_evt_o <= '0;
      rx_done_o <= 1'b0;
      rx_ext_o <= 1'b0;
      rx_id_o <= 32'h0;
    end else begin
      tx_evt_o.sent_ok <= 3'h0;
      tx_evt_o.failed <= 3'h0;
      rx_done_o <= frame_i;
      // identifier lines toggle outside frames, never hold stale data
      rx_ext_o <= frame_i ? frame_id_i[32] : ~rx_ext_o;
      rx_id_o <= frame_i ? frame_id_i[31:0] : ~rx_id_o;
      if (sel == 2'h3) begin
        cnt <= 0;
        tx_evt_o.started <= 3'h0;
      end else begin
        cnt <= cnt + 1;
        if (cnt == lead) tx_evt_o.started[sel] <= 1'b1;
        if (cnt == lead + 6) begin
          cnt <= 0;
          tx_evt_o.started <= 3'h0;
          if (fail_i) tx_evt_o.failed[sel] <= 1'b1;
          else tx_evt_o.sent_ok[sel] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/can_irq_tx_abort_accept_filter_test.sv ====
// self-checking bench for the can host control block
`timescale 1ns/10ps
`default_nettype none
module can_irq_tx_abort_accept_filter_test;
  logic                     clk_sys_i = 1'b0;
  logic                     reset_i = 1'b1;
  logic                     psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]               paddr_i = 8'h00;
  logic [31:0]              pwdata_i = 32'h0, prdata_o, rx_id_i;
  canif_pkg::canif_flags_t  flags_i = '0;
  logic [7:0]               rx_err_cnt_i = 8'h00, tx_err_cnt_i = 8'h00;
  logic                     sleep_i = 1'b0, slow = 1'b0, fail = 1'b0, frame = 1'b0;
  logic [32:0]              frame_id = 33'h0;
  canif_pkg::canif_tx_evt_t tx_evt_i;
  logic                     pready_o, pslverr_o, rx_done_i, rx_ext_i, last_err;
  logic                     wake_irq_o, err_irq_o, rx_irq_o, tx_irq_o, rx_accept_o, soft_reset_o;
  logic [2:0]               tx_sched_o, abort_req_o;
  int                       fails = 0, total_checks = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  canif_ctrl uut (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .flags_i, .rx_err_cnt_i, .tx_err_cnt_i, .sleep_i,
    .tx_evt_i, .rx_done_i, .rx_ext_i, .rx_id_i, .wake_irq_o, .err_irq_o, .rx_irq_o,
    .tx_irq_o, .tx_sched_o, .abort_req_o, .rx_accept_o, .soft_reset_o);
  canif_node_model node (.clk_sys_i, .reset_i, .slow_i(slow), .fail_i(fail), .frame_i(frame),
    .frame_id_i(frame_id), .tx_sched_i(tx_sched_o), .tx_evt_o(tx_evt_i), .rx_done_o(rx_done_i),
    .rx_ext_o(rx_ext_i), .rx_id_o(rx_id_i));
  ////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n == 20) chk(32'h0, 32'h1, "bus hang");
    r = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, x, m);
  endtask
  task automatic wait_idle(input int b);
    int n;
    n = 0;
    repeat (2) @(negedge clk_sys_i);
    while (tx_sched_o[b] !== 1'b0 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 200) chk(32'h0, 32'h1, "transmit hang");
  endtask
  // filter model: index of lowest hitting filter, -1 when rejected
  function automatic int hit_of(int md, logic ext, logic [31:0] id, logic [31:0] c, logic [31:0] m);
    logic [31:0] ok;
    ok = ~(id ^ c) | m;
    if (md == 3) return -1;
    if (md == 0) return (ext ? &ok : &ok[15:0]) ? 0 : -1;
    for (int k = 0; k < 4; k++) begin
      if (md == 1 && k < 2 && &ok[k*16+:16]) return k;
      if (md == 2 && &ok[k*8+:8]) return k;
    end
    return -1;
  endfunction
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fails++;
    print_verdict();
  end
  initial begin
    logic [31:0] c, m, id;
    logic [7:0]  en, fl;
    logic        ext, acc;
    int          h;
    void'($urandom(32'hE09E));
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rx_err_cnt_i <= 8'($urandom);
    tx_err_cnt_i <= 8'($urandom);
    sleep_i <= 1'b1;
    rdc(canif_pkg::ADDR_MOD_CTRL, 32'h1, "soft bit");
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h7, "flags reset");
    rdc(canif_pkg::ADDR_TX_CTRL, 32'h0, "ctrl reset");
    wr(canif_pkg::ADDR_RX_IRQ_EN, 32'hFF);
    rdc(canif_pkg::ADDR_RX_IRQ_EN, 32'h0, "enable held");
    rdc(8'h40, 32'h0, "unmapped");
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    wr(canif_pkg::ADDR_RX_ERR_CNT, 32'hFF);
    rdc(canif_pkg::ADDR_RX_ERR_CNT, {24'h0, rx_err_cnt_i}, "rx count");
    rdc(canif_pkg::ADDR_TX_ERR_CNT, {24'h0, tx_err_cnt_i}, "tx count");
    rdc(canif_pkg::ADDR_RX_STATUS, 32'h1, "sleep");
    $display("test reset done");
    for (int md = 0; md < 4; md++) begin
      for (int t = 0; t < 3; t++) begin
        c = $urandom;
        m = $urandom | $urandom;
        m[10:8] = 3'h7;
        ext = (t == 1);
        id = (t == 0) ? $urandom : (c & ~m) | ($urandom & m);
        wr(canif_pkg::ADDR_MOD_CTRL, 32'h1);
        wr(canif_pkg::ADDR_FILT_MODE, 32'(md * 16));
        for (int k = 0; k < 4; k++) begin
          wr(canif_pkg::ADDR_CODE_BASE + 8'(4 * k), {24'h0, c[k*8+:8]});
          wr(canif_pkg::ADDR_MASK_BASE + 8'(4 * k), {24'h0, m[k*8+:8]});
        end
        wr(canif_pkg::ADDR_MOD_CTRL, 32'h0);
        wr(canif_pkg::ADDR_CODE_BASE, {24'h0, ~c[7:0]});
        rdc(canif_pkg::ADDR_CODE_BASE, {24'h0, c[7:0]}, "locked code");
        @(posedge clk_sys_i);
        frame <= 1'b1;
        frame_id <= {ext, id};
        @(posedge clk_sys_i);
        frame <= 1'b0;
        h = hit_of(md, ext, id, c, m);
        acc = 1'b0;
        repeat (4) begin
          @(negedge clk_sys_i);
          acc = acc | rx_accept_o;
        end
        chk({31'h0, acc}, {31'h0, h >= 0}, "accept");
        if (h >= 0) rdc(canif_pkg::ADDR_FILT_MODE, 32'(md * 16 + h), "hit");
      end
    end
    $display("test filter done");
    for (int i = 0; i < 12; i++) begin
      en = 8'($urandom);
      fl = 8'($urandom);
      wr(canif_pkg::ADDR_RX_IRQ_EN, {24'h0, en});
      rdc(canif_pkg::ADDR_RX_IRQ_EN, {24'h0, en}, "enable");
      flags_i <= fl;
      repeat (3) @(negedge clk_sys_i);
      chk({29'h0, wake_irq_o, err_irq_o, rx_irq_o}, {29'h0, en[7] & fl[7],
        |(en[6:1] & fl[6:1]), en[0] & fl[0]}, "irq");
      @(posedge clk_sys_i);
      flags_i <= '0;
    end
    $display("test irq done");
    wr(canif_pkg::ADDR_TX_CTRL, 32'h7);
    repeat (2) @(negedge clk_sys_i);
    chk({31'h0, tx_irq_o}, 32'h1, "tx irq");
    wr(canif_pkg::ADDR_TX_FLAGS, 32'h1);
    wait_idle(0);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h7, "sent");
    @(posedge clk_sys_i);
    slow <= 1'b1;
    wr(canif_pkg::ADDR_TX_FLAGS, 32'h2);
    wr(canif_pkg::ADDR_TX_CTRL, 32'h27);
    wait_idle(1);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h27, "aborted");
    rdc(canif_pkg::ADDR_TX_CTRL, 32'h7, "abort cleared");
    wr(canif_pkg::ADDR_TX_FLAGS, 32'h70);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h27, "ack read only");
    wr(canif_pkg::ADDR_TX_FLAGS, 32'h2);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h5, "ack cleared");
    chk({29'h0, tx_sched_o}, 32'h2, "scheduled");
    wr(canif_pkg::ADDR_TX_CTRL, 32'h27);
    wait_idle(1);
    @(posedge clk_sys_i);
    slow <= 1'b0;
    fail <= 1'b1;
    wr(canif_pkg::ADDR_TX_FLAGS, 32'h4);
    wr(canif_pkg::ADDR_TX_CTRL, 32'h47);
    repeat (2) @(negedge clk_sys_i);
    chk({29'h0, abort_req_o}, 32'h4, "abort pending");
    wait_idle(2);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h67, "failed abort");
    wr(canif_pkg::ADDR_TX_CTRL, 32'h17);
    rdc(canif_pkg::ADDR_TX_CTRL, 32'h7, "abort on empty");
    $display("test transmit done");
    wr(canif_pkg::ADDR_MOD_CTRL, 32'h1);
    rdc(canif_pkg::ADDR_TX_FLAGS, 32'h7, "flags soft");
    chk({31'h0, soft_reset_o}, 32'h1, "soft out");
    rdc(canif_pkg::ADDR_TX_CTRL, 32'h0, "ctrl soft");
    rdc(canif_pkg::ADDR_RX_IRQ_EN, 32'h0, "enable soft");
    $display("test soft reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
